// [src/flash_lane_io.sv]
// Pin lane logic of a serial flash: output, quad lanes and pause
`timescale 1ns/10ps
`include "lane_consts.svh"
module flash_lane_io
    import lane_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI_I,
    output logic SI_O,
    output logic SI_OE_N,
    input wire logic SO_I,
    output logic SO_O,
    output logic SO_OE_N,
    input wire logic WP_N_I,
    output logic WP_N_O,
    output logic WP_N_OE_N,
    input wire logic PAUSE_N_I,
    output logic PAUSE_N_O,
    output logic PAUSE_N_OE_N,
    input wire logic [1:0] LANE_MODE,
    input wire logic DRIVE_EN,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic [7:0] RX_DATA,
    output logic RX_VALID,
    input wire logic OP_BUSY,
    output logic PROT_LOCK,
    output logic STANDBY,
    output logic PAUSED
);
    // Pin synchronisers; lane 2/3 reset high like the pad pull-ups
    logic [1:0] cs_m_q, sck_m_q, si_m_q, so_m_q, wp_m_q, ps_m_q;
    logic sck_d1_q;
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cs_m_q <= {2{`PIN_IDLE_LVL}};
            sck_m_q <= 2'h0;
            si_m_q <= 2'h0;
            so_m_q <= 2'h0;
            wp_m_q <= {2{`PIN_IDLE_LVL}};
            ps_m_q <= {2{`PIN_IDLE_LVL}};
            sck_d1_q <= 1'b0;
        end else begin
            cs_m_q <= {cs_m_q[0], CS_N};
            sck_m_q <= {sck_m_q[0], SCK};
            si_m_q <= {si_m_q[0], SI_I};
            so_m_q <= {so_m_q[0], SO_I};
            wp_m_q <= {wp_m_q[0], WP_N_I};
            ps_m_q <= {ps_m_q[0], PAUSE_N_I};
            sck_d1_q <= sck_m_q[1];
        end
    end
    wire cs_n_s = cs_m_q[1];
    wire sck_s = sck_m_q[1];
    wire wp_n_s = wp_m_q[1];
    wire pause_n_s = ps_m_q[1];
    wire lane_lo = si_m_q[1];
    wire lane_hi = so_m_q[1];
    wire sck_rise = sck_s && !sck_d1_q;
    wire sck_fall = !sck_s && sck_d1_q;

    lane_mode_t mode;
    assign mode = lane_mode_t'(LANE_MODE);
    wire quad = (mode == MODE_QUAD_RD) || (mode == MODE_QUAD_IN);

    // Link state
    link_st_t st_q, st_d;
    wire pause_start = !pause_n_s && !sck_s && !quad;
    always_comb begin
        case (st_q)
            ST_IDLE: st_d = cs_n_s ? ST_IDLE : ST_SEL;
            ST_SEL: begin
                if (cs_n_s) begin
                    st_d = ST_IDLE;
                end else if (pause_start) begin
                    st_d = ST_PAUSE;
                end else begin
                    st_d = ST_SEL;
                end
            end
            // Counters are frozen, not cleared, so the transfer resumes intact
            ST_PAUSE: begin
                if (cs_n_s) begin
                    st_d = ST_IDLE;
                end else if (pause_n_s) begin
                    st_d = ST_SEL;
                end else begin
                    st_d = ST_PAUSE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end
    wire active = (st_q == ST_SEL) && !cs_n_s;
    wire rx_edge = active && sck_rise && !DRIVE_EN;
    wire tx_edge = active && sck_fall && DRIVE_EN;

    // Read path buffer
    byte_stream_if #(.W(`BYTE_W)) fill_s ();
    byte_stream_if #(.W(`BYTE_W)) drain_s ();
    assign fill_s.valid = TX_VALID;
    assign fill_s.data = TX_DATA;
    assign TX_READY = fill_s.ready;
    byte_fifo #(.W(`BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .in_s(fill_s),
        .out_s(drain_s)
    );

    // Transmit shifter, top bits of a byte leave first
    logic [7:0] tx_sh_q;
    logic [2:0] tx_cnt_q;
    logic [3:0] out_q;
    logic [3:0] oe_n_q;
    wire need_byte = (tx_cnt_q == `CNT_ZERO);
    wire [7:0] cur = need_byte ? (drain_s.valid ? drain_s.data : `FILL_ONES) : tx_sh_q;
    assign drain_s.ready = tx_edge && need_byte;
    wire [2:0] chunks = (mode == MODE_SINGLE) ? `CHUNKS_SINGLE :
        (mode == MODE_DUAL_RD) ? `CHUNKS_DUAL : `CHUNKS_QUAD;
    wire [2:0] step = (mode == MODE_SINGLE) ? 3'h1 : (mode == MODE_DUAL_RD) ? 3'h2 : 3'h4;
    wire [3:0] out_d = (mode == MODE_SINGLE) ? {2'h3, cur[7], 1'b1} :
        (mode == MODE_DUAL_RD) ? {2'h3, cur[7], cur[6]} :
        cur[7:4];
    // Lane enables: 0 SI, 1 SO, 2 WP, 3 PAUSE
    wire drv = active && DRIVE_EN && (mode != MODE_QUAD_IN);
    wire [3:0] oe_n_d = {~(drv && mode == MODE_QUAD_RD), ~(drv && mode == MODE_QUAD_RD),
        ~drv, ~(drv && mode != MODE_SINGLE)};
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_sh_q <= 8'h00;
            tx_cnt_q <= `CNT_ZERO;
            out_q <= 4'hf;
            oe_n_q <= 4'hf;
        end else begin
            oe_n_q <= oe_n_d;
            if (cs_n_s) begin
                tx_cnt_q <= `CNT_ZERO;
            end else if (tx_edge) begin
                out_q <= out_d;
                tx_sh_q <= 8'(cur << step);
                tx_cnt_q <= need_byte ? chunks : 3'(tx_cnt_q - 1'b1);
            end
        end
    end
    assign SI_O = out_q[0];
    assign SO_O = out_q[1];
    assign WP_N_O = out_q[2];
    assign PAUSE_N_O = out_q[3];
    assign SI_OE_N = oe_n_q[0];
    assign SO_OE_N = oe_n_q[1];
    assign WP_N_OE_N = oe_n_q[2];
    assign PAUSE_N_OE_N = oe_n_q[3];

    // Receive shifter; quad program takes four lanes per rising edge
    logic [7:0] rx_sh_q;
    logic [2:0] rx_cnt_q;
    logic [7:0] rx_q;
    logic rx_v_q;
    wire quad_in = (mode == MODE_QUAD_IN);
    wire [3:0] quad_bits = {pause_n_s, wp_n_s, lane_hi, lane_lo};
    wire [7:0] rx_next = quad_in ? {rx_sh_q[3:0], quad_bits} : {rx_sh_q[6:0], lane_lo};
    wire rx_last = quad_in ? (rx_cnt_q == `CHUNKS_QUAD) : (rx_cnt_q == `CHUNKS_SINGLE);
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_sh_q <= 8'h00;
            rx_cnt_q <= `CNT_ZERO;
            rx_q <= 8'h00;
            rx_v_q <= 1'b0;
        end else begin
            rx_v_q <= 1'b0;
            if (cs_n_s) begin
                rx_cnt_q <= `CNT_ZERO;
            end else if (rx_edge) begin
                rx_sh_q <= rx_next;
                rx_cnt_q <= rx_last ? `CNT_ZERO : 3'(rx_cnt_q + 1'b1);
                if (rx_last) begin
                    rx_q <= rx_next;
                    rx_v_q <= 1'b1;
                end
            end
        end
    end
    assign RX_DATA = rx_q;
    assign RX_VALID = rx_v_q;

    // Status; busy is never gated by the pause state
    logic lock_q, stby_q;
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            lock_q <= 1'b0;
            stby_q <= 1'b1;
        end else begin
            lock_q <= !quad && !wp_n_s;
            stby_q <= cs_n_s && !OP_BUSY;
        end
    end
    assign PROT_LOCK = lock_q;
    assign STANDBY = stby_q;
    assign PAUSED = (st_q == ST_PAUSE);

    a_so_release: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        cs_n_s |=> SO_OE_N && SI_OE_N)
        else $error("output lane driven while deselected");
    a_pause_quiet: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        st_q == ST_PAUSE |=> oe_n_q == 4'hf)
        else $error("lane driven during pause");
    a_pause_entry: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        $rose(st_q == ST_PAUSE) |-> $past(!sck_s && !cs_n_s && !pause_n_s))
        else $error("pause began without clock low and select");
    a_pause_frozen: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        st_q == ST_PAUSE && !cs_n_s |=> $stable(rx_sh_q) && $stable(tx_cnt_q))
        else $error("transfer state moved during pause");
    a_rx_on_rise: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        $changed(rx_sh_q) |-> $past(rx_edge))
        else $error("input sampled off a rising edge");
    a_tx_on_fall: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        $changed(out_q) |-> $past(tx_edge))
        else $error("output changed off a falling edge");
    a_lock_follow: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        !quad && !wp_n_s |=> PROT_LOCK)
        else $error("protection input did not lock");
    a_standby_busy: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        cs_n_s && OP_BUSY |=> !STANDBY)
        else $error("standby while self-timed operation busy");
    a_dual_lanes: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        drv && mode == MODE_DUAL_RD |=> !SO_OE_N && !SI_OE_N && WP_N_OE_N)
        else $error("dual read lanes wrong");
endmodule : flash_lane_io

// [src/lane_consts.svh]
// Constants for the serial flash pin lane logic
// What this block does
// - Single lane reads shift each bit out on the output line at falling clock.
// - Dual reads use output line as lane 1, two bits per falling edge.
// - Output line is released to high impedance while chip select is high.
// - Protection input governs hardware block locking in single and dual operation.
// - Quad program turns protection and pause pins into input lanes 2 and 3.
// - Quad reads drive four bits per falling edge on lanes 3 to 0.
// - Protection and pause inputs default high through internal pull-ups.
// - Pause suspends communication, keeps selection and transfer state, no reset.
// - While paused, clock edges and input data are ignored, output floats.
// - Pause starts only with chip select asserted and clock low.
// - Pause never disturbs a self-timed program or erase in progress.
// - Command, address and write data are sampled on rising clock edges.
// - Each operation opens on chip select falling and closes on its rise.
// - Deselected device ignores input data and stands by once not busy.
`ifndef LANE_CONSTS_SVH
`define LANE_CONSTS_SVH
`define BYTE_W 8
`define FIFO_DEPTH 8
`define PIN_IDLE_LVL 1'b1
`define CNT_ZERO 3'h0
`define CHUNKS_SINGLE 3'h7
`define CHUNKS_DUAL 3'h3
`define CHUNKS_QUAD 3'h1
`define FILL_ONES 8'h00ff
`endif

// [src/lane_pkg.sv]
// Types shared by the serial flash pin lane logic
package lane_pkg;
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_DUAL_RD = 2'h1,
        MODE_QUAD_RD = 2'h3,
        MODE_QUAD_IN = 2'h2
    } lane_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SEL = 2'h1,
        ST_PAUSE = 2'h3
    } link_st_t;
endpackage : lane_pkg

// [src/byte_stream_if.sv]
// Valid/ready byte stream between the lane logic modules
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// [src/byte_fifo.sv]
// Read data FIFO with registered output stage
`timescale 1ns/10ps
`include "lane_consts.svh"
module byte_fifo #(
    parameter int W = `BYTE_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    byte_stream_if.snk in_s,
    byte_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    logic ov_q;
    logic [W-1:0] od_q;
    wire full = (cnt_q == (AW+1)'(DEPTH));
    wire empty = (cnt_q == '0);
    wire push = in_s.valid && !full;
    wire pop = !empty && (!ov_q || out_s.ready);
    assign in_s.ready = !full;
    assign out_s.valid = ov_q;
    assign out_s.data = od_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
            rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
            cnt_q <= (AW+1)'(cnt_q + push - pop);
            if (pop) begin
                od_q <= mem_q[rd_q];
                ov_q <= 1'b1;
            end else if (out_s.ready) begin
                ov_q <= 1'b0;
            end
        end
    end

    a_fifo_no_ovf: assert property (@(posedge clk) disable iff (!rst_n)
        full && !pop |=> cnt_q == (AW+1)'(DEPTH))
        else $error("fifo count changed while full");
endmodule : byte_fifo

// [sim/spi_host_model.sv]
// Behavioural SPI host: select, link clock and the four data lanes
`timescale 1ns/10ps
module spi_host_model (
    output logic cs_n,
    output logic sck,
    input wire logic [3:0] dev_o,
    input wire logic [3:0] dev_oe_n,
    output wire logic [3:0] lane
);
    logic [3:0] drv_v = 4'h0;
    logic [3:0] drv_en = 4'h0;
    logic tog = 1'b0;
    // Released plain lines wander so a stale level never passes
    always #43 tog = ~tog;
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign lane[i] = !dev_oe_n[i] ? dev_o[i] : drv_en[i] ? drv_v[i] :
            (i >= 2) ? 1'b1 : tog;
    end
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
    end
    // Odd offset keeps the link out of phase with the sampling clock
    task automatic sel(input logic on);
        #137;
        cs_n = !on;
        #400;
    endtask : sel
    // Mode 3 period: fall launches, rise samples
    task automatic bit_cyc(input logic [3:0] v, input logic [3:0] en, output logic [3:0] got);
        sck = 1'b0;
        drv_v = v;
        drv_en = en;
        #400;
        got = lane;
        sck = 1'b1;
        #400;
    endtask : bit_cyc
    task automatic hold_on();
        sck = 1'b0;
        drv_en = 4'h0;
        #400;
        drv_en[3] = 1'b1;
        drv_v[3] = 1'b0;
        repeat (3) begin
            #400 sck = 1'b1;
            #400 sck = 1'b0;
        end
    endtask : hold_on
    task automatic hold_off(output logic [3:0] got);
        #400;
        drv_en[3] = 1'b0;
        #400;
        got = lane;
        sck = 1'b1;
        #400;
    endtask : hold_off
endmodule : spi_host_model

// [sim/tb.sv]
// Self-checking bench for the serial flash pin lane logic
`timescale 1ns/10ps
module tb;
    logic REF_CLK = 1'b0;
    logic RESETN, DRIVE_EN, TX_VALID, OP_BUSY;
    logic [1:0] LANE_MODE;
    logic [7:0] TX_DATA, RX_DATA;
    logic SI_O, SI_OE_N, SO_O, SO_OE_N, WP_N_O, WP_N_OE_N, PAUSE_N_O, PAUSE_N_OE_N;
    logic TX_READY, RX_VALID, PROT_LOCK, STANDBY, PAUSED;
    wire cs_n, sck;
    wire [3:0] lane;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] rxq[$];
    logic [7:0] expq[$];
    always #50 REF_CLK = ~REF_CLK;
    spi_host_model i_host (.cs_n(cs_n), .sck(sck), .lane(lane),
        .dev_o({PAUSE_N_O, WP_N_O, SO_O, SI_O}),
        .dev_oe_n({PAUSE_N_OE_N, WP_N_OE_N, SO_OE_N, SI_OE_N}));
    flash_lane_io #(.FIFO_DEPTH(8)) i_dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .CS_N(cs_n),
        .SCK(sck), .SI_I(lane[0]), .SI_O(SI_O), .SI_OE_N(SI_OE_N), .SO_I(lane[1]),
        .SO_O(SO_O), .SO_OE_N(SO_OE_N), .WP_N_I(lane[2]), .WP_N_O(WP_N_O),
        .WP_N_OE_N(WP_N_OE_N), .PAUSE_N_I(lane[3]), .PAUSE_N_O(PAUSE_N_O),
        .PAUSE_N_OE_N(PAUSE_N_OE_N), .LANE_MODE(LANE_MODE), .DRIVE_EN(DRIVE_EN),
        .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RX_DATA(RX_DATA),
        .RX_VALID(RX_VALID), .OP_BUSY(OP_BUSY), .PROT_LOCK(PROT_LOCK), .STANDBY(STANDBY),
        .PAUSED(PAUSED));
    // Mid-cycle sampling keeps clear of the edge that launches the pulse
    always @(negedge REF_CLK) begin
        if (RX_VALID === 1'b1) rxq.push_back(RX_DATA);
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask : idle
    task automatic wr_byte(input logic [7:0] b, input logic quad);
        logic [3:0] g;
        if (quad) begin
            i_host.bit_cyc(b[7:4], 4'hf, g);
            i_host.bit_cyc(b[3:0], 4'hf, g);
        end else for (int k = 7; k >= 0; k--) i_host.bit_cyc({3'h0, b[k]}, 4'h1, g);
    endtask : wr_byte
    // Pause lands before bit pz; pz beyond the byte means none
    task automatic rd_byte(input int bpf, input int pz);
        logic [3:0] g;
        logic [7:0] b;
        b = 8'h00;
        for (int k = 0; k < 8 / bpf; k++) begin
            if (k == pz) begin
                i_host.hold_on();
                idle(5);
                chk(PAUSED, 8'h01);
                chk(SO_OE_N, 8'h01);
                i_host.hold_off(g);
            end else i_host.bit_cyc(4'h0, 4'h0, g);
            b = (b << bpf) | (bpf == 1 ? {7'h00, g[1]} : bpf == 2 ? {6'h00, g[1:0]} : {4'h0, g});
        end
        chk(b, expq.size() ? expq.pop_front() : 8'hff);
    endtask : rd_byte
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    initial begin
        logic [7:0] b;
        int n;
        RESETN = 1'b0;
        LANE_MODE = 2'h0;
        DRIVE_EN = 1'b0;
        TX_DATA = 8'h00;
        TX_VALID = 1'b0;
        OP_BUSY = 1'b0;
        void'($urandom(32'h2fda));
        idle(6);
        chk({STANDBY, PAUSED, SO_OE_N, TX_READY}, 8'h0b);
        RESETN = 1'b1;
        idle(2);
        for (int m = 0; m < 2; m++) begin
            LANE_MODE = m ? 2'h2 : 2'h0;
            i_host.sel(1'b1);
            for (int k = 0; k < 2; k++) begin
                b = $urandom;
                expq.push_back(b);
                wr_byte(b, m);
            end
            i_host.sel(1'b0);
            idle(4);
            chk(rxq.size(), 8'h02);
            while (rxq.size()) chk(rxq.pop_front(), expq.pop_front());
        end
        $display("test write done");
        // Last quad nibble is still parked on the lanes
        i_host.drv_v = 4'h0;
        i_host.drv_en = 4'h4;
        LANE_MODE = 2'h0;
        idle(5);
        chk(PROT_LOCK, 8'h01);
        LANE_MODE = 2'h2;
        idle(5);
        chk(PROT_LOCK, 8'h00);
        repeat (4) begin
            LANE_MODE = 2'($urandom);
            idle(5);
            chk(PROT_LOCK, {7'h00, !LANE_MODE[1]});
        end
        i_host.drv_en = 4'h0;
        LANE_MODE = 2'h0;
        idle(5);
        chk(PROT_LOCK, 8'h00);
        $display("test protect done");
        n = 0;
        for (int k = 0; k < 40; k++) begin
            TX_DATA = $urandom;
            TX_VALID = 1'($urandom);
            if (TX_VALID && TX_READY === 1'b1) begin
                n++;
                expq.push_back(TX_DATA);
            end
            idle(1);
        end
        TX_VALID = 1'b0;
        chk(n, 8'h09);
        chk(TX_READY, 8'h00);
        DRIVE_EN = 1'b1;
        for (int m = 0; m < 3; m++) begin
            LANE_MODE = m == 0 ? 2'h0 : m == 1 ? 2'h1 : 2'h3;
            i_host.sel(1'b1);
            repeat (3) rd_byte(1 << m, 9);
            i_host.sel(1'b0);
            idle(4);
            chk({SI_OE_N, SO_OE_N, WP_N_OE_N, PAUSE_N_OE_N}, 8'h0f);
        end
        $display("test read done");
        TX_DATA = $urandom;
        TX_VALID = 1'b1;
        expq.push_back(TX_DATA);
        idle(1);
        TX_VALID = 1'b0;
        LANE_MODE = 2'h0;
        OP_BUSY = 1'b1;
        i_host.sel(1'b1);
        rd_byte(1, 4);
        rd_byte(1, 9);
        i_host.sel(1'b0);
        idle(4);
        chk(STANDBY, 8'h00);
        OP_BUSY = 1'b0;
        idle(4);
        chk(STANDBY, 8'h01);
        repeat (4) begin
            OP_BUSY = 1'($urandom);
            idle(4);
            chk(STANDBY, {7'h00, !OP_BUSY});
        end
        $display("test pause done");
        test_done();
    end
endmodule : tb
